// File: design/sync_trigger_action_dispatch.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Fire when own compare register condition holds
// R2 - Compare fires only on false-to-true change
// R3 - Fire on internal timer reaching preset
// R4 - Fire on drive state change events
// R5 - Fire when split pulsing starts, command or action
// R6 - Fire when final split pulse completes
// R7 - Fire per split pulse when repeating
// R8 - Rising edge on own pin n fires
// R9 - Pin high at enable: wait low then rise
// R10 - Falling edge on own pin n fires
// R11 - Pin low at enable: wait high then fall
// R12 - Gated edges need qualifier pin level
// R13 - Gated edges share enable-time suppression
// R14 - Software picks no-operation for chained sets
// R15 - Codes 01-09,0F,10 use own register/pin
// R16 - 0A/0B/0C start relative, counter, absolute drive
// R17 - 0D/0E start continuous plus/minus drive
// R18 - 17/18 start/stop split; 00 does nothing
// R19 - Four-bit factor code selects activation source
// R20 - 01-04 load register into drive parameters
// R21 - 05-08 save positions, timer, speed (set 0) or accel (set 1) into register
// R22 - 0F/10 copy register to pulses, start drive
// R23 - 11-16 stops, speed change, timer control
// R24 - Sets run in parallel; action next cycle
module sync_trigger_action_dispatch
    import sync_trigger_pkg::*;
(
    input  wire logic                  clk,            // System clock
    input  wire logic                  reset_n,        // Async reset
    input  wire sync_cfg_s [3:0]       cfg,            // Per-set setup
    input  wire logic [7:0]            gpIn,           // Purpose pins
    input  wire logic                  mrWrite,        // Host reg write
    input  wire logic [1:0]            mrIndex,        // Register select
    input  wire logic [DATA_W-1:0]     mrData,         // Write data
    input  wire logic [DATA_W-1:0]     logicalPos,     // Logical count
    input  wire logic [DATA_W-1:0]     realPos,        // Real count
    input  wire logic [DATA_W-1:0]     currentSpeed,   // Present speed
    input  wire logic [DATA_W-1:0]     currentAccel,   // Present accel
    input  wire drive_evt_s            driveEvt,       // Drive events
    input  wire logic                  splitStartCmd,  // Host split start
    input  wire logic                  splitEnd,       // Last split done
    input  wire logic                  splitPulse,     // Split pulse edge
    input  wire logic                  timerLoadCmd,   // Host timer load
    input  wire logic [DATA_W-1:0]     timerLoadData,  // Timer preset
    input  wire logic                  timerStartCmd,  // Host timer start
    output logic [3:0][DATA_W-1:0]     mrOut,          // Register values
    output param_load_s [3:0]          loadOut,        // Parameter loads
    output drive_cmd_s                 driveCmd,       // Drive commands
    output logic [3:0]                 pinPulseReq,    // Pin pulse start
    output logic [3:0]                 fired,          // Set fired pulse
    output logic [DATA_W-1:0]          timerValue,     // Timer count
    output logic                       timerRunning    // Timer active
);

    logic [3:0][DATA_W-1:0] mr_r, mr_nxt;
    param_load_s [3:0]      load_r, load_nxt;
    drive_cmd_s             cmd_r, cmd_nxt;
    logic [3:0]             pinReq_r, pinReq_nxt;
    logic [3:0]             fired_r, fired_nxt;
    logic [3:0]             prevLvl_r, prevLvl_nxt;
    logic [3:0]             armed_r, armed_nxt;
    logic [3:0]             done_r, done_nxt;
    logic [DATA_W-1:0]      timer_r, timer_nxt;
    logic [DATA_W-1:0]      preset_r, preset_nxt;
    logic                   run_r, run_nxt;
    logic [3:0]             fireNow;
    logic [3:0]             cmpLvl;
    logic                   timerUp;
    logic                   splitStarted;

    function automatic logic cmpHit(input logic [1:0] obj,
                                    input logic [1:0] cond,
                                    input logic [DATA_W-1:0] ref_v,
                                    input logic [DATA_W-1:0] lp,
                                    input logic [DATA_W-1:0] rp,
                                    input logic [DATA_W-1:0] ct,
                                    input logic [DATA_W-1:0] cv);
        logic signed [DATA_W-1:0] o;
        logic signed [DATA_W-1:0] r;
        logic                     hit;
        o   = signed'(lp);
        r   = signed'(ref_v);
        hit = 1'b0;
        case (obj)
            OBJ_REAL:  o = signed'(rp);
            OBJ_TIMER: o = signed'(ct);
            OBJ_SPEED: o = signed'(cv);
            default:   o = signed'(lp);
        endcase
        case (cond)
            COND_GT: hit = o > r;
            COND_LT: hit = o < r;
            COND_EQ: hit = o == r;
            default: hit = o >= r;
        endcase
        return hit;
    endfunction

    assign timerUp      = run_r && (timer_r == preset_r); // R3
    assign splitStarted = splitStartCmd || cmd_r.splitStart; // R5

    // Factor detection for all four sets in parallel
    always_comb begin
        for (int s = 0; s < NUM_SETS; s++) begin
            logic lvl;
            logic qual;
            logic rise;
            logic fall;
            logic evt;
            lvl  = 1'b0;
            rise = 1'b0;
            fall = 1'b0;
            qual = gpIn[s + QUAL_PIN_OFS];
            cmpLvl[s] = cmpHit(cfg[s].cmpObj, cfg[s].cmpCond, mr_r[s],
                               logicalPos, realPos, timer_r,
                               currentSpeed); // R1
            lvl  = (cfg[s].factor == FACT_COMPARE) ? cmpLvl[s] : gpIn[s];
            // Armed only one cycle after enable, so a level already
            // active at enable time cannot look like an edge
            rise = armed_r[s] && lvl && !prevLvl_r[s]; // R2 R9 R13
            fall = armed_r[s] && !lvl && prevLvl_r[s]; // R11 R13
            evt  = 1'b0;
            case (cfg[s].factor) // R19
                FACT_COMPARE:     evt = rise; // R1 R2
                FACT_TIMER:       evt = timerUp; // R3
                FACT_DRV_START:   evt = driveEvt.start; // R4
                FACT_CONST_START: evt = driveEvt.constStart; // R4
                FACT_CONST_END:   evt = driveEvt.constEnd; // R4
                FACT_DRV_END:     evt = driveEvt.finish; // R4
                FACT_SPLIT_START: evt = splitStarted; // R5
                FACT_SPLIT_END:   evt = splitEnd; // R6
                FACT_SPLIT_OUT:   evt = splitPulse; // R7
                FACT_RISE:        evt = rise; // R8
                FACT_FALL:        evt = fall; // R10
                FACT_LOW_RISE:    evt = rise && !qual; // R12
                FACT_HIGH_RISE:   evt = rise && qual; // R12
                FACT_LOW_FALL:    evt = fall && !qual; // R12
                FACT_HIGH_FALL:   evt = fall && qual; // R12
                default:          evt = 1'b0;
            endcase
            // Without repeat a set fires once per enable
            fireNow[s]     = cfg[s].enable && armed_r[s] && evt &&
                             (cfg[s].repeatOn || !done_r[s]); // R7 R24
            prevLvl_nxt[s] = lvl;
            armed_nxt[s]   = cfg[s].enable;
            done_nxt[s]    = cfg[s].enable && (done_r[s] || fireNow[s]);
        end
    end

    // Action dispatch; results appear one cycle after detection
    always_comb begin
        mr_nxt     = mr_r;
        cmd_nxt    = '0;
        pinReq_nxt = '0;
        fired_nxt  = fireNow; // R24
        run_nxt    = run_r;
        timer_nxt  = run_r ? timer_r + 32'h0000_0001 : timer_r;
        preset_nxt = timerLoadCmd ? timerLoadData : preset_r; // R3
        if (timerUp) begin
            run_nxt   = 1'b0;
            timer_nxt = TIMER_RESET;
        end
        if (timerStartCmd) begin
            run_nxt   = 1'b1; // R3
            timer_nxt = TIMER_RESET;
        end
        for (int s = 0; s < NUM_SETS; s++) begin
            load_nxt[s] = '{valid: 1'b0, target: TGT_SPEED, data: mr_r[s]};
            if (fireNow[s]) begin
                case (cfg[s].action)
                    ACT_LOAD_SPEED: load_nxt[s].valid = 1'b1; // R15 R20
                    ACT_LOAD_PULSES: begin
                        load_nxt[s].valid  = 1'b1; // R20
                        load_nxt[s].target = TGT_PULSES;
                    end
                    ACT_LOAD_SPLIT: begin
                        load_nxt[s].valid  = 1'b1; // R20
                        load_nxt[s].target = TGT_SPLIT;
                    end
                    ACT_LOAD_SET: begin
                        load_nxt[s].valid = 1'b1; // R15 R20
                        case (s)
                            0:       load_nxt[s].target = TGT_LOGPOS;
                            1:       load_nxt[s].target = TGT_REALPOS;
                            2:       load_nxt[s].target = TGT_INITSPEED;
                            default: load_nxt[s].target = TGT_ACCEL;
                        endcase
                    end
                    ACT_SAVE_LOG:   mr_nxt[s] = logicalPos; // R21
                    ACT_SAVE_REAL:  mr_nxt[s] = realPos; // R21
                    ACT_SAVE_TIMER: mr_nxt[s] = timer_r; // R21
                    ACT_SAVE_SET: begin
                        if (s == 0) begin
                            mr_nxt[s] = currentSpeed; // R21
                        end else if (s == 1) begin
                            mr_nxt[s] = currentAccel; // R21
                        end
                    end
                    ACT_PIN_PULSE:  pinReq_nxt[s] = 1'b1; // R15
                    ACT_REL_START:  cmd_nxt.relStart = 1'b1; // R16
                    ACT_CREL_START: cmd_nxt.cntRelStart = 1'b1; // R16
                    ACT_ABS_START:  cmd_nxt.absStart = 1'b1; // R16
                    ACT_POS_CONT:   cmd_nxt.posContStart = 1'b1; // R17
                    ACT_NEG_CONT:   cmd_nxt.negContStart = 1'b1; // R17
                    ACT_REL_MR: begin
                        load_nxt[s].valid  = 1'b1; // R22
                        load_nxt[s].target = TGT_PULSES;
                        cmd_nxt.relStart   = 1'b1;
                    end
                    ACT_ABS_MR: begin
                        load_nxt[s].valid  = 1'b1; // R22
                        load_nxt[s].target = TGT_PULSES;
                        cmd_nxt.absStart   = 1'b1;
                    end
                    ACT_DEC_STOP:   cmd_nxt.decStop = 1'b1; // R23
                    ACT_INST_STOP:  cmd_nxt.instStop = 1'b1; // R23
                    ACT_SPEED_UP:   cmd_nxt.speedUp = 1'b1; // R23
                    ACT_SPEED_DOWN: cmd_nxt.speedDown = 1'b1; // R23
                    ACT_TIMER_START: begin
                        run_nxt   = 1'b1; // R23
                        timer_nxt = TIMER_RESET;
                    end
                    ACT_TIMER_STOP: run_nxt = 1'b0; // R23
                    ACT_SPLIT_START: cmd_nxt.splitStart = 1'b1; // R18
                    ACT_SPLIT_STOP:  cmd_nxt.splitStop = 1'b1; // R18
                    default: ; // R18
                endcase
            end
        end
        // Host write overrides a save landing in the same cycle
        if (mrWrite) begin
            mr_nxt[mrIndex] = mrData;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mr_r      <= {NUM_SETS{MR_RESET}};
            load_r    <= '0;
            cmd_r     <= '0;
            pinReq_r  <= '0;
            fired_r   <= '0;
            prevLvl_r <= '0;
            armed_r   <= '0;
            done_r    <= '0;
            timer_r   <= TIMER_RESET;
            preset_r  <= TIMER_RESET;
            run_r     <= 1'b0;
        end else begin
            mr_r      <= mr_nxt;
            load_r    <= load_nxt;
            cmd_r     <= cmd_nxt;
            pinReq_r  <= pinReq_nxt;
            fired_r   <= fired_nxt;
            prevLvl_r <= prevLvl_nxt;
            armed_r   <= armed_nxt;
            done_r    <= done_nxt;
            timer_r   <= timer_nxt;
            preset_r  <= preset_nxt;
            run_r     <= run_nxt;
        end
    end

    assign mrOut        = mr_r;
    assign loadOut      = load_r;
    assign driveCmd     = cmd_r;
    assign pinPulseReq  = pinReq_r;
    assign fired        = fired_r;
    assign timerValue   = timer_r;
    assign timerRunning = run_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_enable_suppress: assert property ( // R2
        $rose(cfg[0].enable) |-> !fireNow[0])
        else $error("set fired in its enable cycle");
    a_pin_rise_fire: assert property ( // R8
        (armed_r[0] && cfg[0].enable && cfg[0].repeatOn &&
         cfg[0].factor == FACT_RISE && $past(cfg[0].factor) == FACT_RISE
         && $rose(gpIn[0])) |-> fireNow[0])
        else $error("rising pin edge missed");
    a_fall_needs_edge: assert property ( // R10
        (fireNow[1] && cfg[1].factor == FACT_FALL) |->
        !gpIn[1] && $past(gpIn[1]))
        else $error("fall fired without falling edge");
    a_gate_qual_low: assert property ( // R12
        (fireNow[2] && cfg[2].factor == FACT_LOW_RISE) |->
        !gpIn[QUAL_PIN_OFS + 2] && gpIn[2])
        else $error("gated fire with wrong qualifier");
    a_compare_true: assert property ( // R1
        (fireNow[3] && cfg[3].factor == FACT_COMPARE) |->
        cmpLvl[3] && !prevLvl_r[3])
        else $error("compare fire without true transition");
    a_action_next: assert property ( // R24
        (fireNow[1] && cfg[1].action == ACT_DEC_STOP) |=>
        driveCmd.decStop && fired[1])
        else $error("stop action not issued next cycle");
    a_save_logical: assert property ( // R21
        (fireNow[3] && cfg[3].action == ACT_SAVE_LOG && !mrWrite) |=>
        mrOut[3] == $past(logicalPos))
        else $error("logical position not saved");
    a_load_set2: assert property ( // R20
        (fireNow[2] && cfg[2].action == ACT_LOAD_SET) |=>
        loadOut[2].valid && loadOut[2].target == TGT_INITSPEED)
        else $error("set two load target wrong");
    a_timer_expire: assert property ( // R3
        timerUp && !timerStartCmd && !(|fireNow) |=>
        !timerRunning && timerValue == TIMER_RESET)
        else $error("timer did not stop at preset");
    a_mr_drive: assert property ( // R22
        (fireNow[0] && cfg[0].action == ACT_ABS_MR) |=>
        driveCmd.absStart && loadOut[0].target == TGT_PULSES &&
        loadOut[0].data == $past(mr_r[0]))
        else $error("register drive start wrong");

    c_pin_fire:   cover property (fireNow[0] && cfg[0].factor == FACT_RISE);
    c_timer_up:   cover property (timerUp);
    c_chain:      cover property (cmd_r.splitStart ##0 fireNow[1]);
    c_all_sets:   cover property (&fireNow);

endmodule

// File: design/sync_trigger_pkg.sv
package sync_trigger_pkg;

    localparam int NUM_SETS     = 4;
    localparam int DATA_W       = 32;
    localparam int QUAL_PIN_OFS = 4;

    // Activation factor codes
    localparam logic [3:0] FACT_NONE        = 4'h0;
    localparam logic [3:0] FACT_COMPARE     = 4'h1;
    localparam logic [3:0] FACT_TIMER       = 4'h2;
    localparam logic [3:0] FACT_DRV_START   = 4'h3;
    localparam logic [3:0] FACT_CONST_START = 4'h4;
    localparam logic [3:0] FACT_CONST_END   = 4'h5;
    localparam logic [3:0] FACT_DRV_END     = 4'h6;
    localparam logic [3:0] FACT_SPLIT_START = 4'h7;
    localparam logic [3:0] FACT_SPLIT_END   = 4'h8;
    localparam logic [3:0] FACT_SPLIT_OUT   = 4'h9;
    localparam logic [3:0] FACT_RISE        = 4'hA;
    localparam logic [3:0] FACT_FALL        = 4'hB;
    localparam logic [3:0] FACT_LOW_RISE    = 4'hC;
    localparam logic [3:0] FACT_HIGH_RISE   = 4'hD;
    localparam logic [3:0] FACT_LOW_FALL    = 4'hE;
    localparam logic [3:0] FACT_HIGH_FALL   = 4'hF;

    // Action codes
    localparam logic [4:0] ACT_NONE        = 5'h00;
    localparam logic [4:0] ACT_LOAD_SPEED  = 5'h01;
    localparam logic [4:0] ACT_LOAD_PULSES = 5'h02;
    localparam logic [4:0] ACT_LOAD_SPLIT  = 5'h03;
    localparam logic [4:0] ACT_LOAD_SET    = 5'h04;
    localparam logic [4:0] ACT_SAVE_LOG    = 5'h05;
    localparam logic [4:0] ACT_SAVE_REAL   = 5'h06;
    localparam logic [4:0] ACT_SAVE_TIMER  = 5'h07;
    localparam logic [4:0] ACT_SAVE_SET    = 5'h08;
    localparam logic [4:0] ACT_PIN_PULSE   = 5'h09;
    localparam logic [4:0] ACT_REL_START   = 5'h0A;
    localparam logic [4:0] ACT_CREL_START  = 5'h0B;
    localparam logic [4:0] ACT_ABS_START   = 5'h0C;
    localparam logic [4:0] ACT_POS_CONT    = 5'h0D;
    localparam logic [4:0] ACT_NEG_CONT    = 5'h0E;
    localparam logic [4:0] ACT_REL_MR      = 5'h0F;
    localparam logic [4:0] ACT_ABS_MR      = 5'h10;
    localparam logic [4:0] ACT_DEC_STOP    = 5'h11;
    localparam logic [4:0] ACT_INST_STOP   = 5'h12;
    localparam logic [4:0] ACT_SPEED_UP    = 5'h13;
    localparam logic [4:0] ACT_SPEED_DOWN  = 5'h14;
    localparam logic [4:0] ACT_TIMER_START = 5'h15;
    localparam logic [4:0] ACT_TIMER_STOP  = 5'h16;
    localparam logic [4:0] ACT_SPLIT_START = 5'h17;
    localparam logic [4:0] ACT_SPLIT_STOP  = 5'h18;

    // Compare object and condition selections
    localparam logic [1:0] OBJ_LOGICAL = 2'h0;
    localparam logic [1:0] OBJ_REAL    = 2'h1;
    localparam logic [1:0] OBJ_TIMER   = 2'h2;
    localparam logic [1:0] OBJ_SPEED   = 2'h3;
    localparam logic [1:0] COND_GE     = 2'h0;
    localparam logic [1:0] COND_GT     = 2'h1;
    localparam logic [1:0] COND_LT     = 2'h2;
    localparam logic [1:0] COND_EQ     = 2'h3;

    localparam logic [DATA_W-1:0] MR_RESET    = 32'h0000_0000;
    localparam logic [DATA_W-1:0] TIMER_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        TGT_SPEED, TGT_PULSES, TGT_SPLIT, TGT_LOGPOS,
        TGT_REALPOS, TGT_INITSPEED, TGT_ACCEL
    } load_target_e;

    typedef struct packed {
        logic         enable;
        logic         repeatOn;
        logic [3:0]   factor;
        logic [4:0]   action;
        logic [1:0]   cmpObj;
        logic [1:0]   cmpCond;
    } sync_cfg_s;

    typedef struct packed {
        logic              valid;
        load_target_e      target;
        logic [DATA_W-1:0] data;
    } param_load_s;

    typedef struct packed {
        logic start;
        logic constStart;
        logic constEnd;
        logic finish;
    } drive_evt_s;

    typedef struct packed {
        logic relStart;
        logic cntRelStart;
        logic absStart;
        logic posContStart;
        logic negContStart;
        logic decStop;
        logic instStop;
        logic speedUp;
        logic speedDown;
        logic splitStart;
        logic splitStop;
    } drive_cmd_s;

endpackage

// File: verification/axis_model.sv
`timescale 1ns/1ps
// Axis stand-in: turns start and stop commands into drive events
module axis_model
    import sync_trigger_pkg::*;
(
    input  wire logic              clk,      // System clock
    input  wire logic              reset_n,  // Async reset
    input  wire drive_cmd_s        driveCmd, // Commands from dispatch
    output drive_evt_s             driveEvt, // Drive state events
    output logic [DATA_W-1:0]      realPos   // Moves while driving
);
    logic driving;
    logic go;
    logic halt;

    assign go = driveCmd.relStart | driveCmd.cntRelStart | driveCmd.absStart
              | driveCmd.posContStart | driveCmd.negContStart;
    assign halt = driveCmd.decStop | driveCmd.instStop;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            driveEvt <= '0;
            driving  <= 1'b0;
            realPos  <= '0;
        end else begin
            driveEvt       <= '0;
            driveEvt.start <= go;
            driveEvt.constStart <= driveEvt.start;
            driveEvt.finish <= halt & driving;
            driving        <= go | (driving & ~halt);
            if (driving) begin
                realPos <= realPos + 32'h0000_0001;
            end
        end
    end
endmodule

// File: verification/sync_trigger_action_dispatch_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    badCount++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module sync_trigger_action_dispatch_tb_top;
    import sync_trigger_pkg::*;
    localparam logic [4:0] ACTS [11] = '{5'h0A, 5'h0B, 5'h0C, 5'h0D,
        5'h0E, 5'h11, 5'h12, 5'h13, 5'h14, 5'h17, 5'h18};
    logic                      clk = 1'b0;
    logic                      reset_n = 1'b0;
    sync_cfg_s [3:0]           cfg = '0;
    logic [7:0]                gpIn = '0;
    logic                      mrWrite = 1'b0;
    logic [1:0]                mrIndex = '0;
    logic [DATA_W-1:0]         mrData = '0;
    logic [DATA_W-1:0]         logicalPos = '0;
    logic [DATA_W-1:0]         realPos;
    drive_evt_s                driveEvt;
    logic                      splitStartCmd = 1'b0;
    logic                      splitEnd = 1'b0;
    logic                      splitPulse = 1'b0;
    logic                      timerLoadCmd = 1'b0;
    logic [DATA_W-1:0]         timerLoadData = '0;
    logic                      timerStartCmd = 1'b0;
    logic [3:0][DATA_W-1:0]    mrOut;
    param_load_s [3:0]         loadOut;
    drive_cmd_s                driveCmd;
    logic [3:0]                pinPulseReq;
    logic [3:0]                fired;
    logic [DATA_W-1:0]         timerValue;
    logic                      timerRunning;
    int                        badCount = 0;
    int                        comparisons = 0;
    int                        fireCount [4] = '{default: 0};

    always #25 clk = ~clk;

    sync_trigger_action_dispatch dut (.clk(clk), .reset_n(reset_n),
        .cfg(cfg), .gpIn(gpIn), .mrWrite(mrWrite), .mrIndex(mrIndex),
        .mrData(mrData), .logicalPos(logicalPos), .realPos(realPos),
        .currentSpeed(32'h0000_0010), .currentAccel(32'h0000_0020),
        .driveEvt(driveEvt), .splitStartCmd(splitStartCmd),
        .splitEnd(splitEnd), .splitPulse(splitPulse),
        .timerLoadCmd(timerLoadCmd), .timerLoadData(timerLoadData),
        .timerStartCmd(timerStartCmd), .mrOut(mrOut), .loadOut(loadOut),
        .driveCmd(driveCmd), .pinPulseReq(pinPulseReq), .fired(fired),
        .timerValue(timerValue), .timerRunning(timerRunning));

    axis_model partner (.clk(clk), .reset_n(reset_n), .driveCmd(driveCmd),
        .driveEvt(driveEvt), .realPos(realPos));

    always @(posedge clk) begin
        for (int k = 0; k < NUM_SETS; k++) begin
            if (fired[k] === 1'b1) begin
                fireCount[k]++;
            end
        end
    end

    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [1:0] i, input logic [DATA_W-1:0] d);
        mrIndex = i;
        mrData  = d;
        mrWrite = 1'b1;
        @(negedge clk);
        mrWrite = 1'b0;
    endtask

    task automatic arm(input int n, input logic [3:0] f,
                       input logic [4:0] a, input logic r);
        cfg[n].enable = 1'b0;
        cfg[n].factor = f;
        cfg[n].action = a;
        cfg[n].repeatOn = r;
        @(negedge clk);
        cfg[n].enable = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    // Watch fired[n] for a few cycles; outputs stay readable on return
    task automatic expectFire(input int n, input logic e);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 12 && !hit; i++) begin
            @(negedge clk);
            hit = (fired[n] === 1'b1);
        end
        `CHK("fired", e, hit)
        if (e && !hit) begin
            reportAndStop();
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        reportAndStop();
    end

    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        `CHK("driveCmd", 11'h000, driveCmd)
        `CHK("timerRunning", 1'b0, timerRunning)
        // Rising edge, pin already high at enable
        gpIn[0] = 1'b1;
        arm(0, FACT_RISE, ACT_INST_STOP, 1'b1);
        expectFire(0, 1'b0);
        gpIn[0] = 1'b0;
        @(negedge clk);
        gpIn[0] = 1'b1;
        expectFire(0, 1'b1);
        `CHK("instStop", 1'b1, driveCmd.instStop)
        // Falling edge, pin already low at enable
        arm(1, FACT_FALL, ACT_PIN_PULSE, 1'b0);
        expectFire(1, 1'b0);
        gpIn[1] = 1'b1;
        @(negedge clk);
        gpIn[1] = 1'b0;
        expectFire(1, 1'b1);
        `CHK("pinPulseReq", 4'h2, pinPulseReq)
        // Gated rise needs qualifier low
        wr(2'h2, 32'h0000_1234);
        gpIn[6] = 1'b1;
        arm(2, FACT_LOW_RISE, ACT_LOAD_SPEED, 1'b0);
        gpIn[2] = 1'b1;
        expectFire(2, 1'b0);
        gpIn[2] = 1'b0;
        gpIn[6] = 1'b0;
        @(negedge clk);
        gpIn[2] = 1'b1;
        expectFire(2, 1'b1);
        `CHK("loadValid", 1'b1, loadOut[2].valid)
        `CHK("loadTarget", TGT_SPEED, loadOut[2].target)
        `CHK("loadData", 32'h0000_1234, loadOut[2].data)
        // Compare already true at enable, then false, then true
        wr(2'h3, 32'h0000_0064);
        logicalPos = 32'h0000_00C8;
        cfg[3].cmpObj = OBJ_LOGICAL;
        cfg[3].cmpCond = COND_GE;
        arm(3, FACT_COMPARE, ACT_SAVE_LOG, 1'b0);
        expectFire(3, 1'b0);
        logicalPos = 32'h0000_0032;
        @(negedge clk);
        logicalPos = 32'h0000_0096;
        expectFire(3, 1'b1);
        `CHK("mrOut3", 32'h0000_0096, mrOut[3])
        // Timer expiry saves the count into register 0
        timerLoadData = 32'h0000_0005;
        timerLoadCmd = 1'b1;
        @(negedge clk);
        timerLoadCmd = 1'b0;
        arm(0, FACT_TIMER, ACT_SAVE_TIMER, 1'b0);
        timerStartCmd = 1'b1;
        @(negedge clk);
        timerStartCmd = 1'b0;
        expectFire(0, 1'b1);
        `CHK("mrOut0", 32'h0000_0005, mrOut[0])
        // Every code that issues only a drive command, counting drive events on sets 0, 2, 3
        arm(0, FACT_DRV_START, ACT_NONE, 1'b1);
        arm(2, FACT_CONST_START, ACT_NONE, 1'b1);
        arm(3, FACT_DRV_END, ACT_NONE, 1'b1);
        fireCount = '{default: 0};
        gpIn[1] = 1'b0;
        for (int i = 0; i < 11; i++) begin
            arm(1, FACT_RISE, ACTS[i], 1'b0);
            gpIn[1] = 1'b1;
            expectFire(1, 1'b1);
            `CHK("driveCmd", 11'h400 >> i, driveCmd)
            gpIn[1] = 1'b0;
        end
        repeat (5) @(negedge clk);
        `CHK("startFires", 5, fireCount[0])
        `CHK("constFires", 5, fireCount[2])
        `CHK("endFires", 1, fireCount[3])
        // Gated falls: register drive on set 0, parameter load on set 2
        arm(0, FACT_LOW_FALL, ACT_ABS_MR, 1'b0);
        arm(2, FACT_HIGH_FALL, ACT_LOAD_SET, 1'b0);
        gpIn = 8'h40;
        expectFire(0, 1'b1);
        `CHK("fired2", 1'b1, fired[2])
        `CHK("absStart", 1'b1, driveCmd.absStart)
        `CHK("loadPulses", TGT_PULSES, loadOut[0].target)
        `CHK("loadMr0", 32'h0000_0005, loadOut[0].data)
        `CHK("loadSet2", TGT_INITSPEED, loadOut[2].target)
        // No-operation factor ignores its pin
        arm(1, FACT_NONE, ACT_INST_STOP, 1'b1);
        gpIn[1] = 1'b1;
        expectFire(1, 1'b0);
        // Split factors with no action; output factor repeats
        for (int i = 0; i < 3; i++) begin
            arm(3, FACT_SPLIT_START + 4'(i), ACT_NONE, 1'b1);
            {splitStartCmd, splitEnd, splitPulse} = 3'h4 >> i;
            // Fire pulse stands one cycle, so look right after the event
            @(negedge clk);
            {splitStartCmd, splitEnd, splitPulse} = 3'h0;
            `CHK("splitFire", 1'b1, fired[3])
            `CHK("driveCmd", 11'h000, driveCmd)
        end
        splitPulse = 1'b1;
        @(negedge clk);
        splitPulse = 1'b0;
        `CHK("splitRepeat", 1'b1, fired[3])
        reportAndStop();
    end
endmodule
